// [logic/fpd_decoder.v]
// Coprocessor instruction decoder: data operations, register
// transfers and compares, with host flag mapping and an APB window.
// Assumes instruction and compare inputs come from core_clk_i logic.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "fpd_consts.vh"

module fpd_decoder #(
    parameter NUM_FREGS = 8,
    parameter K_WIDTH   = 32
) (
    // Clock and reset
    input  wire                 core_clk_i,
    input  wire                 reset_i,
    // APB slave
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [11:0]          paddr,
    input  wire [31:0]          pwdata,
    output wire [31:0]          prdata,
    output wire                 pready,
    output wire                 pslverr,
    // Instruction from host
    input  wire                 instr_valid_i,
    input  wire [31:0]          instr_i,
    input  wire                 supervisor_i,
    // Store/restore of a float register by the transfer unit
    input  wire                 restore_valid_i,
    input  wire [2:0]           restore_reg_i,
    input  wire                 restore_tag_i,
    // Compare outcome from datapath
    input  wire                 cmp_done_i,
    input  wire                 cmp_less_i,
    input  wire                 cmp_equal_i,
    input  wire                 cmp_unordered_i,
    input  wire                 cmp_snan_i,
    // Decoded instruction
    output reg                  dec_valid_o,
    output reg  [1:0]           dec_class_o,
    output reg  [4:0]           dec_func_o,
    output reg                  dec_monadic_o,
    output reg  [1:0]           dec_prec_o,
    output reg  [1:0]           dec_round_final_o,
    output reg  [1:0]           dec_round_step_o,
    output reg                  dec_to_host_o,
    output reg  [2:0]           dec_dest_o,
    output reg  [2:0]           dec_first_o,
    output reg  [2:0]           dec_second_o,
    output reg                  dec_use_const_o,
    output wire [K_WIDTH-1:0]   const_value_o,
    output reg                  dec_second_unnorm_o,
    output reg                  dec_trap_o,
    // Host flags
    output reg                  flags_valid_o,
    output reg  [3:0]           flags_nzcv_o,
    output reg                  cmp_exception_o,
    output wire [NUM_FREGS-1:0] save_tags_o
);

    // Decode state
    reg                  alt_cmp_reg;
    reg                  cmp_signal_reg;
    reg  [NUM_FREGS-1:0] unnorm_tag_reg;
    reg  [NUM_FREGS-1:0] unnorm_tag_next;
    reg  [15:0]          trap_count_reg;
    reg  [31:0]          rdata_reg;

    // Decoder combinational terms
    reg        is_cp;
    reg        is_data;
    reg        is_xfer;
    reg        is_cmp;
    reg  [4:0] data_code;
    reg  [3:0] xfer_code;
    reg  [2:0] cmp_code;
    reg  [1:0] prec;
    reg  [1:0] rnd;
    reg        trap_next;
    reg  [1:0] class_next;
    reg  [4:0] func_next;
    reg        transcend;
    reg        writes_dest;

    wire [3:0] rd_field = instr_i[`FPD_RD_HI:`FPD_RD_LO];
    wire [2:0] fd_field = instr_i[`FPD_FD_HI:`FPD_FD_LO];
    wire [2:0] fm_field = instr_i[`FPD_FM_HI:`FPD_FM_LO];

    always @* begin
        // Field positions of the host coprocessor layout
        is_cp     = instr_i[`FPD_CP_CLASS_HI:`FPD_CP_CLASS_LO] == `FPD_CP_CLASS_VAL &&
                    instr_i[`FPD_CP_NUM_HI:`FPD_CP_NUM_LO] == `FPD_CP_NUM_VAL;
        data_code = {instr_i[`FPD_OPC_HI:`FPD_OPC_LO], instr_i[`FPD_FORM_BIT]};
        xfer_code = {instr_i[`FPD_XOP_HI:`FPD_XOP_LO], instr_i[`FPD_DIR_BIT]};
        cmp_code  = instr_i[`FPD_XOP_HI:`FPD_XOP_LO];
        prec      = {instr_i[`FPD_PREC_HI_BIT], instr_i[`FPD_PREC_LO_BIT]};
        rnd       = instr_i[`FPD_RND_HI:`FPD_RND_LO];
        is_data   = is_cp && !instr_i[`FPD_KIND_BIT];
        is_xfer   = is_cp && instr_i[`FPD_KIND_BIT];
        // Compare is a transfer to host register 15
        is_cmp    = is_xfer && instr_i[`FPD_DIR_BIT] && cmp_code[2] &&
                    rd_field == `FPD_RD_PC;
        trap_next   = 1'b0;
        class_next  = `FPD_CLASS_NONE;
        func_next   = 5'h00;
        transcend   = 1'b0;
        writes_dest = 1'b0;
        if (is_data) begin
            class_next  = `FPD_CLASS_DATA;
            func_next   = data_code;
            writes_dest = 1'b1;
            case (data_code)
                `FPD_ADD_OP, `FPD_MULTIPLY_OP, `FPD_SUBTRACT_OP,
                `FPD_REV_SUB_OP: begin
                    trap_next = 1'b0;
                end
                `FPD_DIVIDE_OP, `FPD_REV_DIV_OP, `FPD_QUICK_MUL_OP,
                `FPD_QUICK_DIV_OP, `FPD_QUICK_RDIV_OP: begin
                    // Quick forms run as the plain ones
                    trap_next = 1'b0;
                end
                `FPD_RAISE_OP, `FPD_REV_RAISE_OP, `FPD_POLAR_OP: begin
                    transcend = 1'b1;
                end
                `FPD_REMAINDER_OP: begin
                    trap_next = 1'b0;
                end
                `FPD_UNDEF_A_OP, `FPD_UNDEF_B_OP, `FPD_UNDEF_C_OP: begin
                    trap_next   = 1'b1;
                    writes_dest = 1'b0;
                end
                `FPD_MOVE_OP, `FPD_MOVE_NEG_OP, `FPD_MAGNITUDE_OP,
                `FPD_ROUND_INT_OP, `FPD_SQRT_OP: begin
                    trap_next = 1'b0;
                end
                `FPD_LOG10_OP, `FPD_NATURAL_LG_OP, `FPD_NAT_POWER_OP: begin
                    transcend = 1'b1;
                end
                `FPD_Y_OVER_R_OP, `FPD_X_OVER_R_OP, `FPD_Y_OVER_X_OP,
                `FPD_INV_Y_R_OP, `FPD_INV_X_R_OP, `FPD_INV_Y_X_OP: begin
                    transcend = 1'b1;
                end
                `FPD_UNNORM_RND_OP, `FPD_NORMALISE_OP: begin
                    trap_next = 1'b0;
                end
                default: begin
                    trap_next = 1'b1;
                end
            endcase
            if (prec == `FPD_PREC_BAD) begin
                trap_next   = 1'b1;
                writes_dest = 1'b0;
            end
        end else if (is_cmp) begin
            class_next = `FPD_CLASS_CMP;
            func_next  = {2'h0, cmp_code};
            // Reserved efgh must be zero
            trap_next  = prec != 2'h0 || rnd != 2'h0;
        end else if (is_xfer) begin
            class_next = `FPD_CLASS_XFER;
            func_next  = {1'b0, xfer_code};
            case (xfer_code)
                `FPD_INT_TO_FLOAT_OP: begin
                    trap_next = prec == `FPD_PREC_BAD;
                end
                `FPD_FLOAT_TO_INT_OP: begin
                    trap_next = prec != 2'h0;
                end
                `FPD_WRITE_STAT_OP, `FPD_READ_STAT_OP: begin
                    trap_next = prec != 2'h0 || rnd != 2'h0;
                end
                `FPD_WRITE_CTRL_OP, `FPD_READ_CTRL_OP: begin
                    // Privileged
                    trap_next = !supervisor_i || prec != 2'h0 || rnd != 2'h0;
                end
                default: begin
                    // 011x and 1xxx outside compares
                    trap_next = 1'b1;
                end
            endcase
        end
    end

    // Unnormalised tags: set by 11101, cleared by any other data operation write.
    // A restore puts back the saved tag so 11111 still works
    always @* begin
        unnorm_tag_next = unnorm_tag_reg;
        if (restore_valid_i) begin
            unnorm_tag_next[restore_reg_i] = restore_tag_i;
        end
        if (instr_valid_i && writes_dest && !trap_next) begin
            unnorm_tag_next[fd_field] = data_code == `FPD_UNNORM_RND_OP;
        end
    end

    // Save path reads the tags straight from flops
    assign save_tags_o = unnorm_tag_reg;

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dec_valid_o         <= 1'b0;
            dec_class_o         <= `FPD_CLASS_NONE;
            dec_func_o          <= 5'h00;
            dec_monadic_o       <= 1'b0;
            dec_prec_o          <= `FPD_PREC_SINGLE;
            dec_round_final_o   <= `FPD_RND_NEAREST;
            dec_round_step_o    <= `FPD_RND_NEAREST;
            dec_to_host_o       <= 1'b0;
            dec_dest_o          <= 3'h0;
            dec_first_o         <= 3'h0;
            dec_second_o        <= 3'h0;
            dec_use_const_o     <= 1'b0;
            dec_second_unnorm_o <= 1'b0;
            dec_trap_o          <= 1'b0;
            cmp_signal_reg      <= 1'b0;
            unnorm_tag_reg      <= {NUM_FREGS{1'b0}};
            trap_count_reg      <= 16'h0000;
        end else begin
            dec_valid_o    <= instr_valid_i && is_cp;
            unnorm_tag_reg <= unnorm_tag_next;
            if (instr_valid_i && is_cp) begin
                dec_class_o         <= class_next;
                dec_func_o          <= func_next;
                dec_monadic_o       <= is_data && data_code[0];
                dec_prec_o          <= prec;
                dec_round_final_o   <= rnd;
                // Directed mode only on the last step
                dec_round_step_o    <= transcend ? `FPD_RND_NEAREST : rnd;
                dec_to_host_o       <= is_xfer && instr_i[`FPD_DIR_BIT];
                dec_dest_o          <= fd_field;
                dec_first_o         <= instr_i[`FPD_FN_HI:`FPD_FN_LO];
                dec_second_o        <= fm_field;
                dec_use_const_o     <= instr_i[`FPD_CONST_BIT];
                // Constant operands are never unnormalised
                dec_second_unnorm_o <= unnorm_tag_reg[fm_field] &&
                                       !instr_i[`FPD_CONST_BIT];
                dec_trap_o          <= trap_next;
                if (is_cmp) begin
                    cmp_signal_reg <= cmp_code[1];
                end
                // Count wraps silently when full
                if (trap_next) begin
                    trap_count_reg <= trap_count_reg + 16'h0001;
                end
            end
        end
    end

    // Constant operand image, same latency as the decode
    fpd_const_rom #(
        .WIDTH      (K_WIDTH)
    ) u_const_rom (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .index_i    (fm_field),
        .value_o    (const_value_o)
    );

    // Host flags from the compare outcome
    // Kind latched at decode: one compare in flight at a time
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flags_valid_o   <= 1'b0;
            flags_nzcv_o    <= 4'h0;
            cmp_exception_o <= 1'b0;
        end else begin
            flags_valid_o <= cmp_done_i;
            if (cmp_done_i) begin
                // Unordered clears N and Z; C depends on alternate bit
                flags_nzcv_o[3] <= cmp_less_i && !cmp_unordered_i;
                flags_nzcv_o[2] <= cmp_equal_i && !cmp_unordered_i;
                flags_nzcv_o[1] <= cmp_unordered_i ? alt_cmp_reg :
                                   !cmp_less_i;
                flags_nzcv_o[0] <= cmp_unordered_i;
                cmp_exception_o <= cmp_signal_reg ? cmp_unordered_i :
                                   cmp_snan_i;
            end
        end
    end

    // APB slave, zero wait states
    // Writes to read-only offsets drop silently
    wire apb_hit_ctrl  = paddr == `FPD_CTRL_OFS;
    wire apb_hit_stat  = paddr == `FPD_STAT_OFS;
    wire apb_hit_tags  = paddr == `FPD_TAGS_OFS;
    wire apb_hit_traps = paddr == `FPD_TRAPS_OFS;
    wire apb_mapped    = apb_hit_ctrl || apb_hit_stat || apb_hit_tags || apb_hit_traps;

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            alt_cmp_reg <= `FPD_CTRL_RST;
        end else if (psel && penable && pwrite && apb_hit_ctrl) begin
            alt_cmp_reg <= pwdata[`FPD_ALT_CMP_BIT];
        end
    end

    always @* begin
        rdata_reg = 32'h00000000;
        if (apb_hit_ctrl) begin
            rdata_reg[`FPD_ALT_CMP_BIT] = alt_cmp_reg;
        end else if (apb_hit_stat) begin
            rdata_reg = {16'h0000, flags_nzcv_o, 1'b0, cmp_exception_o,
                         dec_trap_o, dec_func_o, dec_class_o, 2'h0};
        end else if (apb_hit_tags) begin
            rdata_reg[NUM_FREGS-1:0] = unnorm_tag_reg;
        end else if (apb_hit_traps) begin
            rdata_reg[15:0] = trap_count_reg;
        end
    end

    // Read data is combinational from registers; unmapped reads give zero
    assign prdata  = (psel && !pwrite) ? rdata_reg : 32'h00000000;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !apb_mapped;

endmodule
`default_nettype wire

// [logic/fpd_consts.vh]
// Constants for the coprocessor instruction decoder: field positions,
// opcode values, register offsets and reset values.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FPD_CONSTS_VH
`define FPD_CONSTS_VH

// Instruction fields
`define FPD_CP_CLASS_HI     27
`define FPD_CP_CLASS_LO     24
`define FPD_CP_CLASS_VAL    4'he
`define FPD_CP_NUM_HI       11
`define FPD_CP_NUM_LO       8
`define FPD_CP_NUM_VAL      4'h1
`define FPD_KIND_BIT        4
`define FPD_OPC_HI          23
`define FPD_OPC_LO          20
`define FPD_FORM_BIT        15
`define FPD_PREC_HI_BIT     19
`define FPD_PREC_LO_BIT     7
`define FPD_RND_HI          6
`define FPD_RND_LO          5
`define FPD_CONST_BIT       3
`define FPD_FM_HI           2
`define FPD_FM_LO           0
`define FPD_FN_HI           18
`define FPD_FN_LO           16
`define FPD_FD_HI           14
`define FPD_FD_LO           12
`define FPD_XOP_HI          23
`define FPD_XOP_LO          21
`define FPD_DIR_BIT         20
`define FPD_RD_HI           15
`define FPD_RD_LO           12
`define FPD_RD_PC           4'hf

// Data operation codes {abcd,j}
`define FPD_ADD_OP          5'h00
`define FPD_MULTIPLY_OP     5'h02
`define FPD_SUBTRACT_OP     5'h04
`define FPD_REV_SUB_OP      5'h06
`define FPD_DIVIDE_OP       5'h08
`define FPD_REV_DIV_OP      5'h0a
`define FPD_RAISE_OP        5'h0c
`define FPD_REV_RAISE_OP    5'h0e
`define FPD_REMAINDER_OP    5'h10
`define FPD_QUICK_MUL_OP    5'h12
`define FPD_QUICK_DIV_OP    5'h14
`define FPD_QUICK_RDIV_OP   5'h16
`define FPD_POLAR_OP        5'h18
`define FPD_UNDEF_A_OP      5'h1a
`define FPD_UNDEF_B_OP      5'h1c
`define FPD_UNDEF_C_OP      5'h1e
`define FPD_MOVE_OP         5'h01
`define FPD_MOVE_NEG_OP     5'h03
`define FPD_MAGNITUDE_OP    5'h05
`define FPD_ROUND_INT_OP    5'h07
`define FPD_SQRT_OP         5'h09
`define FPD_LOG10_OP        5'h0b
`define FPD_NATURAL_LG_OP   5'h0d
`define FPD_NAT_POWER_OP    5'h0f
`define FPD_Y_OVER_R_OP     5'h11
`define FPD_X_OVER_R_OP     5'h13
`define FPD_Y_OVER_X_OP     5'h15
`define FPD_INV_Y_R_OP      5'h17
`define FPD_INV_X_R_OP      5'h19
`define FPD_INV_Y_X_OP      5'h1b
`define FPD_UNNORM_RND_OP   5'h1d
`define FPD_NORMALISE_OP    5'h1f

// Precision and rounding
`define FPD_PREC_SINGLE     2'h0
`define FPD_PREC_DOUBLE     2'h1
`define FPD_PREC_EXT        2'h2
`define FPD_PREC_BAD        2'h3
`define FPD_RND_NEAREST     2'h0
`define FPD_RND_PLUS        2'h1
`define FPD_RND_MINUS       2'h2
`define FPD_RND_ZERO        2'h3

// Register transfer codes {abc,L}
`define FPD_INT_TO_FLOAT_OP 4'h0
`define FPD_FLOAT_TO_INT_OP 4'h1
`define FPD_WRITE_STAT_OP   4'h2
`define FPD_READ_STAT_OP    4'h3
`define FPD_WRITE_CTRL_OP   4'h4
`define FPD_READ_CTRL_OP    4'h5

// Compare codes abc
`define FPD_COMPARE_OP      3'h4
`define FPD_COMPARE_NEG_OP  3'h5
`define FPD_COMPARE_SIG_OP  3'h6
`define FPD_COMPARE_NSIG_OP 3'h7

// Decoded class
`define FPD_CLASS_NONE      2'h0
`define FPD_CLASS_DATA      2'h1
`define FPD_CLASS_XFER      2'h2
`define FPD_CLASS_CMP       2'h3

// Built-in constants, single precision images
`define FPD_K_0_0           32'h00000000
`define FPD_K_1_0           32'h3f800000
`define FPD_K_2_0           32'h40000000
`define FPD_K_3_0           32'h40400000
`define FPD_K_4_0           32'h40800000
`define FPD_K_5_0           32'h40a00000
`define FPD_K_0_5           32'h3f000000
`define FPD_K_10_0          32'h41200000

// Register map (byte addresses)
`define FPD_CTRL_OFS        12'h000
`define FPD_STAT_OFS        12'h004
`define FPD_TAGS_OFS        12'h008
`define FPD_TRAPS_OFS       12'h00c
`define FPD_CTRL_RST        1'h0
`define FPD_ALT_CMP_BIT     0

`endif

// [logic/fpd_const_rom.v]
// Built-in operand constant table, registered read data.
// Assumes index is stable in the cycle the decoder samples it.
`timescale 1ns/100ps
`default_nettype none
`include "fpd_consts.vh"

module fpd_const_rom #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input  wire             core_clk_i,
    input  wire             reset_i,
    // Lookup
    input  wire [2:0]       index_i,
    output reg  [WIDTH-1:0] value_o
);

    reg [WIDTH-1:0] value_next;

    always @* begin
        case (index_i)
            3'h0:    value_next = `FPD_K_0_0;
            3'h1:    value_next = `FPD_K_1_0;
            3'h2:    value_next = `FPD_K_2_0;
            3'h3:    value_next = `FPD_K_3_0;
            3'h4:    value_next = `FPD_K_4_0;
            3'h5:    value_next = `FPD_K_5_0;
            3'h6:    value_next = `FPD_K_0_5;
            3'h7:    value_next = `FPD_K_10_0;
            default: value_next = `FPD_K_0_0;
        endcase
    end

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            value_o <= {WIDTH{1'b0}};
        end else begin
            value_o <= value_next;
        end
    end

endmodule
`default_nettype wire

// [testbench/fpd_decoder_monitor.sv]
// Port checker for the coprocessor decoder.
// Assumes a bind from the testbench top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "fpd_consts.vh"
module fpd_decoder_monitor (
    // Clock, reset and inputs
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic        cmp_done_i,
    input wire logic        cmp_equal_i,
    input wire logic        cmp_unordered_i,
    // Outputs watched
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dec_valid_o,
    input wire logic [4:0]  dec_func_o,
    input wire logic        dec_monadic_o,
    input wire logic        dec_trap_o,
    input wire logic        flags_valid_o,
    input wire logic [3:0]  flags_nzcv_o
);
    wire cop_w = instr_valid_i && instr_i[27:24] == 4'he && instr_i[11:8] == 4'h1;
    default clocking dcb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_data;
        cop_w && !instr_i[`FPD_KIND_BIT];
    endsequence
    a_decode_accept: assert property (cop_w |=> dec_valid_o)
        else $error("decode missing");
    a_decode_refuse: assert property (!cop_w |=> !dec_valid_o)
        else $error("decode without word");
    a_func_join: assert property (s_data |=> dec_func_o == {$past(instr_i[23:20]), $past(instr_i[15])})
        else $error("function code wrong");
    a_form_bit: assert property (s_data |=> dec_monadic_o == $past(instr_i[15]))
        else $error("form wrong");
    a_trap_undef: assert property (s_data ##0 (instr_i[23:20] >= 4'hd && !instr_i[15]) |=> dec_trap_o)
        else $error("undefined code not trapped");
    a_trap_prec: assert property (s_data ##0 (instr_i[19] && instr_i[7]) |=> dec_trap_o)
        else $error("bad precision not trapped");
    a_flags_v: assert property (cmp_done_i |=> flags_valid_o && flags_nzcv_o[0] == $past(cmp_unordered_i))
        else $error("V flag wrong");
    a_flags_z: assert property (cmp_done_i |=> flags_nzcv_o[2] == ($past(cmp_equal_i) && !$past(cmp_unordered_i)))
        else $error("Z flag wrong");
    a_unord_n: assert property (flags_valid_o && flags_nzcv_o[0] |-> !flags_nzcv_o[3])
        else $error("N set when unordered");
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("no ready");
    a_apb_err: assert property (psel && penable && paddr > `FPD_TRAPS_OFS |-> pslverr)
        else $error("no error on unmapped");
endmodule
`default_nettype wire

// [testbench/fpd_host_model.sv]
// Host CPU model: issues coprocessor words and compare outcomes.
// Assumes tasks are called just after a rising edge or at time zero.
`timescale 1ns/100ps
`default_nettype none
module fpd_host_model (
    // Clock
    input  wire logic       core_clk_i,
    // Instruction and compare outcome
    output var logic        instr_valid_o,
    output var logic [31:0] instr_o,
    output var logic        supervisor_o,
    output var logic        cmp_done_o,
    output var logic [3:0]  cmp_o
);
    initial begin
        instr_valid_o = 1'b0;
        instr_o = 32'h0;
        supervisor_o = 1'b0;
        cmp_done_o = 1'b0;
        cmp_o = 4'h0;
    end
    // Idle word inverted so a stale word cannot pass for fresh
    task issue(input logic [31:0] w, input logic sup);
        @(posedge core_clk_i);
        instr_valid_o <= 1'b1;
        instr_o <= w;
        supervisor_o <= sup;
        @(posedge core_clk_i);
        instr_valid_o <= 1'b0;
        instr_o <= ~w;
    endtask
    // Outcome order: less, equal, unordered, signalling
    task outcome(input logic [3:0] o);
        @(posedge core_clk_i);
        cmp_done_o <= 1'b1;
        cmp_o <= o;
        @(posedge core_clk_i);
        cmp_done_o <= 1'b0;
        cmp_o <= ~o;
    endtask
endmodule
`default_nettype wire

// [testbench/fpd_decoder_test.sv]
// Self-checking bench for the coprocessor decoder.
// Assumes the host model drives instructions and compare outcomes.
`timescale 1ns/100ps
`default_nettype none
`include "fpd_consts.vh"
module fpd_decoder_test;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic restore_valid_i = 1'b0;
    logic [2:0] restore_reg_i = 3'h0;
    logic restore_tag_i = 1'b0;
    wire logic instr_valid_i, supervisor_i, cmp_done_i, cmp_less_i, cmp_equal_i;
    wire logic cmp_unordered_i, cmp_snan_i, pready, pslverr, dec_valid_o, dec_monadic_o;
    wire logic dec_to_host_o, dec_use_const_o, dec_second_unnorm_o, dec_trap_o;
    wire logic flags_valid_o, cmp_exception_o;
    wire logic [31:0] instr_i, prdata, const_value_o;
    wire logic [1:0] dec_class_o, dec_prec_o, dec_round_final_o, dec_round_step_o;
    wire logic [4:0] dec_func_o;
    wire logic [2:0] dec_dest_o, dec_first_o, dec_second_o;
    wire logic [3:0] flags_nzcv_o;
    wire logic [7:0] save_tags_o;
    logic [31:0] q;
    logic e;
    int err_total = 0;
    int tests_run = 0;
    fpd_decoder dut_u (.*);
    fpd_host_model host_u (.core_clk_i(core_clk_i), .instr_valid_o(instr_valid_i),
        .instr_o(instr_i), .supervisor_o(supervisor_i), .cmp_done_o(cmp_done_i),
        .cmp_o({cmp_less_i, cmp_equal_i, cmp_unordered_i, cmp_snan_i}));
    always #25 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] dw(logic [4:0] f, logic [1:0] p, logic [1:0] r);
        return 32'hee000100 | {8'h0, f[4:1], p[1], 3'h0, f[0], 7'h0, p[0], r, 5'h0};
    endfunction
    function automatic logic [31:0] xw(logic [3:0] c, logic [3:0] rd);
        return 32'hee000110 | {8'h0, c, 4'h0, rd, 12'h0};
    endfunction
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task iss(input logic [31:0] w, input logic sup);
        host_u.issue(w, sup);
        #1;
        chk("valid", dec_valid_o, 1);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_apb;
        apb(0, `FPD_CTRL_OFS, 0);
        chk("ctrl reset", q, 0);
        apb(1, `FPD_CTRL_OFS, 1);
        apb(0, `FPD_CTRL_OFS, 0);
        chk("ctrl", q[0], 1);
        apb(0, 12'h010, 0);
        chk("unmapped err", e, 1);
        $display("test apb done");
    endtask
    task t_data;
        logic t;
        logic s;
        for (int f = 0; f < 32; f++) begin
            t = f == 5'h1a || f == 5'h1c || f == 5'h1e;
            s = !(f inside {12, 14, 24, 11, 13, 15, 17, 19, 21, 23, 25, 27});
            iss(dw(f[4:0], 0, 1), 1);
            chk("func", dec_func_o, f);
            chk("form", dec_monadic_o, f[0]);
            chk("class", dec_class_o, `FPD_CLASS_DATA);
            chk("trap", dec_trap_o, t);
            chk("step", dec_round_step_o, {1'b0, s});
        end
        for (int k = 0; k < 16; k++) begin
            iss(dw(0, k[3:2], k[1:0]), 1);
            chk("prec", dec_prec_o, k[3:2]);
            chk("round", dec_round_final_o, k[1:0]);
            chk("prec trap", dec_trap_o, k[3:2] == 3);
        end
        for (int k = 0; k < 8; k++) begin
            iss(dw(0, 0, 0) | 32'h8 | k, 1);
            chk("const", const_value_o, k == 0 ? `FPD_K_0_0 : k == 1 ? `FPD_K_1_0 :
                k == 2 ? `FPD_K_2_0 : k == 3 ? `FPD_K_3_0 : k == 4 ? `FPD_K_4_0 :
                k == 5 ? `FPD_K_5_0 : k == 6 ? `FPD_K_0_5 : `FPD_K_10_0);
            chk("use const", dec_use_const_o, 1);
        end
        $display("test data done");
    endtask
    task t_xfer;
        for (int c = 0; c < 16; c++) begin
            iss(xw(c[3:0], 0), 1);
            chk("to host", dec_to_host_o, c[0]);
            chk("xfer class", dec_class_o, `FPD_CLASS_XFER);
            chk("xfer trap", dec_trap_o, c > 5);
            if (c < 6) chk("xfer func", dec_func_o, c);
        end
        iss(xw(4, 0), 0);
        chk("user ctrl", dec_trap_o, 1);
        iss(xw(1, 0) | 32'h80, 1);
        chk("fix prec", dec_trap_o, 1);
        iss(xw(0, 0) | 32'he0, 1);
        chk("flt trap", dec_trap_o, 0);
        chk("flt fields", {dec_prec_o, dec_round_final_o}, 4'h7);
        $display("test transfer done");
    endtask
    task t_cmp;
        logic [3:0] o;
        for (int a = 0; a < 2; a++) begin
            apb(1, `FPD_CTRL_OFS, a);
            for (int k = 4; k < 8; k++) begin
                iss(xw({k[2:0], 1'b1}, 4'hf), 1);
                chk("cmp class", dec_class_o, `FPD_CLASS_CMP);
                chk("cmp func", dec_func_o, k);
                for (int m = 0; m < 5; m++) begin
                    o = m == 0 ? 4'h8 : m == 1 ? 4'h4 : m == 2 ? 4'h0 : m == 3 ? 4'h2 : 4'h3;
                    host_u.outcome(o);
                    #1;
                    chk("nzcv", flags_nzcv_o, {o[3] & !o[1], o[2] & !o[1],
                        o[1] ? a[0] : !o[3], o[1]});
                    chk("exc", cmp_exception_o, k[1] ? o[1] : o[0]);
                end
            end
        end
        $display("test compare done");
    endtask
    task restore(input logic t);
        @(posedge core_clk_i);
        restore_valid_i <= 1'b1;
        restore_reg_i <= 3'h2;
        restore_tag_i <= t;
        @(posedge core_clk_i);
        restore_valid_i <= 1'b0;
        #1;
        chk("tag", save_tags_o[2], t);
    endtask
    task t_tags;
        iss(dw(5'h1d, 0, 0) | 32'h2000, 1);
        chk("unnorm tag", save_tags_o[2], 1);
        chk("dest", dec_dest_o, 2);
        restore(0);
        restore(1);
        iss(dw(0, 0, 0) | 32'h50002, 1);
        chk("second unnorm", dec_second_unnorm_o, 1);
        chk("first", dec_first_o, 5);
        chk("second", dec_second_o, 2);
        $display("test tags done");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Far beyond the few hundred cycles the tests need
    initial begin
        #(50 * 20000);
        err_total++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_apb;
        t_data;
        t_xfer;
        t_cmp;
        t_tags;
        print_verdict;
    end
endmodule
bind fpd_decoder fpd_decoder_monitor mon_u (.*);
`default_nettype wire
